//--- include/bus_flag_pkg.sv
package bus_flag_pkg;

  // Register addresses
  localparam logic [15:0] BUS_FLAG_ADDR = 16'hffa9;
  localparam logic [15:0] CTRL_ONE_ADDR = 16'hffa8;

  // Flag register field positions
  localparam int unsigned FLAG_START_CLEAR_BIT = 7;
  localparam int unsigned FLAG_BUS_BUSY_BIT = 6;
  localparam int unsigned FLAG_INIT_START_BIT = 1;
  localparam int unsigned FLAG_RSV_DISABLE_BIT = 0;

  // Control register one field positions
  localparam int unsigned CR1_WAKEUP_BIT = 7;
  localparam int unsigned CR1_CLOCK_LEVEL_BIT = 5;
  localparam int unsigned CR1_DATA_LEVEL_BIT = 4;
  localparam int unsigned CR1_SETTING_HI_BIT = 3;
  localparam int unsigned CR1_SETTING_LO_BIT = 2;

  // Reset values
  localparam logic [7:0] BUS_FLAG_RESET = 8'h00;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [1:0] CR1_SETTING_RESET = 2'h0;

  // Idle level of both bus wires
  localparam logic [1:0] BUS_IDLE_LEVEL = 2'h3;

  // Permission to generate a start after enabling
  typedef enum logic [2:0] {
    PERM_OFF = 3'b001,
    PERM_WAIT_STOP = 3'b010,
    PERM_READY = 3'b100
  } perm_state_t;

  // Byte write or single-bit write merged onto the current value
  function automatic logic [7:0] merge_write(
    input logic [7:0] current,
    input logic bitMode,
    input logic [2:0] bitSel,
    input logic [7:0] wrData
  );
    logic [7:0] result;
    result = current;
    if (bitMode) begin
      result[bitSel] = wrData[0];
    end else begin
      result = wrData;
    end
    return result;
  endfunction

endpackage

//--- rtl/pin_sync.sv
module pin_sync
  import bus_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstN,
  // Raw pins, clock wire in bit 1
  input wire logic [1:0] pinIn,
  // Synchronised levels
  output logic [1:0] pinSync
);

  logic [1:0] meta_ff;
  logic [1:0] sync_ff;

  // Idle-high reset keeps a false condition from showing at release
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      meta_ff <= BUS_IDLE_LEVEL;
      sync_ff <= BUS_IDLE_LEVEL;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
    end
  end

  assign pinSync = sync_ff;

endmodule

//--- rtl/bus_condition_detect.sv
module bus_condition_detect
  import bus_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstN,
  // Synchronised bus levels
  input wire logic sclLevel,
  input wire logic sdaLevel,
  // One-cycle condition pulses
  output logic startSeen,
  output logic stopSeen
);

  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic startSeen_ff;
  logic stopSeen_ff;
  logic sclHeld;
  logic sdaFall;
  logic sdaRise;

  // Clock must be high on both samples around the data edge
  assign sclHeld = sclLevel & sclPrev_ff;
  assign sdaFall = sdaPrev_ff & ~sdaLevel;
  assign sdaRise = ~sdaPrev_ff & sdaLevel;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      sclPrev_ff <= BUS_IDLE_LEVEL[1];
      sdaPrev_ff <= BUS_IDLE_LEVEL[0];
      startSeen_ff <= 1'b0;
      stopSeen_ff <= 1'b0;
    end else begin
      sclPrev_ff <= sclLevel;
      sdaPrev_ff <= sdaLevel;
      startSeen_ff <= sclHeld & sdaFall;
      stopSeen_ff <= sclHeld & sdaRise;
    end
  end

  assign startSeen = startSeen_ff;
  assign stopSeen = stopSeen_ff;

endmodule

//--- rtl/i2c_bus_flag_register.sv
// Operation
// [RULE_01] Flag byte: start-clear bit 7, busy bit 6, initial-start bit 1, reservation-off bit 0.
// [RULE_02] Bit or byte access; start-clear and busy bits ignore writes.
// [RULE_03] Initial-start and reservation-off bits written only while controller disabled.
// [RULE_04] Failed start with reservation off clears start trigger and sets start-clear.
// [RULE_05] Start-clear cleared by start trigger write, controller disabled, or reset.
// [RULE_06] Busy set on start condition, or on enabling with initial-start at 0.
// [RULE_07] Busy cleared on stop condition, while disabled, and on reset.
// [RULE_08] Initial-start 0 waits for stop before starts; 1 allows starts at once.
// [RULE_09] Initial-start set by software; cleared by software, start condition, reset.
// [RULE_10] Reservation-off bit changes only by software write; reset clears it.
// [RULE_11] Software checks bus quiet before first start when initial-start is 1.
// [RULE_12] Control register one settings written only while disabled, except wakeup; levels read-only.
// [RULE_13] Reset clears flag register and control register one.
// [RULE_14] Flag bits 5 to 2 read zero and ignore writes.
module i2c_bus_flag_register
  import bus_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Processor memory access
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic cpuBitMode,
  input wire logic [2:0] cpuBitSel,
  input wire logic [7:0] cpuWrData,
  output logic [7:0] cpuRdData,
  output logic cpuRdValid,
  // Rest of the controller
  input wire logic controllerEnable,
  input wire logic startTriggerWrite,
  input wire logic startFail,
  output logic startTriggerClear,
  output logic startAllowed,
  // Mode and status levels
  output logic initialStartEnable,
  output logic reservationDisable,
  output logic busBusy,
  output logic addressMatchWakeup,
  output logic [1:0] cr1Settings,
  // Bus wires, sampled only
  input wire logic serialClockPin,
  input wire logic serialDataPin
);

  // Reset release synchroniser
  logic rstMeta_ff;
  logic rstSync_ff;
  logic rstN;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  assign rstN = rstSync_ff;

  // Bus sampling and condition detection
  logic [1:0] pinLevels;
  logic startSeen;
  logic stopSeen;
  logic startEvent;
  logic stopEvent;

  pin_sync u_pin_sync (
    .ref_clk(ref_clk),
    .rstN(rstN),
    .pinIn({serialClockPin, serialDataPin}),
    .pinSync(pinLevels)
  );

  bus_condition_detect u_condition (
    .ref_clk(ref_clk),
    .rstN(rstN),
    .sclLevel(pinLevels[1]),
    .sdaLevel(pinLevels[0]),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // Conditions only count while the controller runs
  assign startEvent = startSeen & controllerEnable;
  assign stopEvent = stopSeen & controllerEnable;

  // Enable edge
  logic enablePrev_ff;
  logic enableRise;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      enablePrev_ff <= 1'b0;
    end else begin
      enablePrev_ff <= controllerEnable;
    end
  end

  assign enableRise = controllerEnable & ~enablePrev_ff;

  // Address decode
  logic selFlag;
  logic selCr1;
  logic wrFlag;
  logic wrCr1;
  logic wrFlagIdle;
  logic wrCr1Idle;

  assign selFlag = (cpuAddr == BUS_FLAG_ADDR);
  assign selCr1 = (cpuAddr == CTRL_ONE_ADDR);
  assign wrFlag = cpuWrite & selFlag;
  assign wrCr1 = cpuWrite & selCr1;
  assign wrFlagIdle = wrFlag & ~controllerEnable; // RULE_03
  assign wrCr1Idle = wrCr1 & ~controllerEnable; // RULE_12

  // Register state
  logic startClear_ff;
  logic busBusy_ff;
  logic initStart_ff;
  logic rsvDisable_ff;
  logic wakeup_ff;
  logic [1:0] cr1Set_ff;
  logic clockLevel_ff;
  logic dataLevel_ff;
  logic trigClear_ff;
  logic [7:0] flagValue;
  logic [7:0] cr1Value;
  logic [7:0] flagMerged;
  logic [7:0] cr1Merged;

  // Read-only and fixed-zero bits drop out of the merge below
  always_comb begin
    flagValue = BUS_FLAG_RESET; // RULE_14
    flagValue[FLAG_START_CLEAR_BIT] = startClear_ff; // RULE_01
    flagValue[FLAG_BUS_BUSY_BIT] = busBusy_ff;
    flagValue[FLAG_INIT_START_BIT] = initStart_ff;
    flagValue[FLAG_RSV_DISABLE_BIT] = rsvDisable_ff;
  end

  always_comb begin
    cr1Value = CTRL_ONE_RESET;
    cr1Value[CR1_WAKEUP_BIT] = wakeup_ff;
    cr1Value[CR1_CLOCK_LEVEL_BIT] = clockLevel_ff;
    cr1Value[CR1_DATA_LEVEL_BIT] = dataLevel_ff;
    cr1Value[CR1_SETTING_HI_BIT] = cr1Set_ff[1];
    cr1Value[CR1_SETTING_LO_BIT] = cr1Set_ff[0];
  end

  assign flagMerged = merge_write(flagValue, cpuBitMode, cpuBitSel, cpuWrData); // RULE_02
  assign cr1Merged = merge_write(cr1Value, cpuBitMode, cpuBitSel, cpuWrData);

  // Next values
  logic nxt_startClear;
  logic nxt_busBusy;
  logic nxt_initStart;
  logic nxt_rsvDisable;
  logic nxt_wakeup;
  logic [1:0] nxt_cr1Set;
  logic failNoReserve;

  assign failNoReserve = controllerEnable & startFail & rsvDisable_ff; // RULE_04

  // Failure beats a trigger write in the same cycle; disabling beats both
  assign nxt_startClear = ~controllerEnable ? 1'b0 :
                          failNoReserve ? 1'b1 : // RULE_04
                          startTriggerWrite ? 1'b0 : // RULE_05
                          startClear_ff;

  assign nxt_busBusy = ~controllerEnable ? 1'b0 : // RULE_07
                       (startEvent | (enableRise & ~initStart_ff)) ? 1'b1 : // RULE_06
                       stopEvent ? 1'b0 : // RULE_07
                       busBusy_ff;

  assign nxt_initStart = wrFlagIdle ? flagMerged[FLAG_INIT_START_BIT] : // RULE_09
                         startEvent ? 1'b0 : // RULE_09
                         initStart_ff;

  assign nxt_rsvDisable = wrFlagIdle ? flagMerged[FLAG_RSV_DISABLE_BIT] : rsvDisable_ff; // RULE_10

  // Wakeup stays writable while running
  assign nxt_wakeup = wrCr1 ? cr1Merged[CR1_WAKEUP_BIT] : wakeup_ff; // RULE_12

  assign nxt_cr1Set = wrCr1Idle ? {cr1Merged[CR1_SETTING_HI_BIT], cr1Merged[CR1_SETTING_LO_BIT]} : // RULE_12
                      cr1Set_ff;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      startClear_ff <= BUS_FLAG_RESET[FLAG_START_CLEAR_BIT]; // RULE_13
      busBusy_ff <= BUS_FLAG_RESET[FLAG_BUS_BUSY_BIT];
      initStart_ff <= BUS_FLAG_RESET[FLAG_INIT_START_BIT];
      rsvDisable_ff <= BUS_FLAG_RESET[FLAG_RSV_DISABLE_BIT];
    end else begin
      startClear_ff <= nxt_startClear;
      busBusy_ff <= nxt_busBusy;
      initStart_ff <= nxt_initStart;
      rsvDisable_ff <= nxt_rsvDisable;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      wakeup_ff <= CTRL_ONE_RESET[CR1_WAKEUP_BIT]; // RULE_13
      cr1Set_ff <= CR1_SETTING_RESET;
      clockLevel_ff <= CTRL_ONE_RESET[CR1_CLOCK_LEVEL_BIT];
      dataLevel_ff <= CTRL_ONE_RESET[CR1_DATA_LEVEL_BIT];
    end else begin
      wakeup_ff <= nxt_wakeup;
      cr1Set_ff <= nxt_cr1Set;
      // Level status only meaningful while running
      clockLevel_ff <= controllerEnable & pinLevels[1]; // RULE_12
      dataLevel_ff <= controllerEnable & pinLevels[0];
    end
  end

  // Trigger clear pulse back to control register zero
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      trigClear_ff <= 1'b0;
    end else begin
      trigClear_ff <= failNoReserve; // RULE_04
    end
  end

  // Start permission after enabling
  perm_state_t perm_ff;
  perm_state_t nxt_perm;

  always_comb begin
    nxt_perm = perm_ff;
    case (perm_ff)
      PERM_OFF: begin
        if (enableRise) begin
          nxt_perm = initStart_ff ? PERM_READY : PERM_WAIT_STOP; // RULE_08
        end
      end
      PERM_WAIT_STOP: begin
        if (!controllerEnable) begin
          nxt_perm = PERM_OFF;
        end else if (stopEvent) begin
          nxt_perm = PERM_READY; // RULE_08
        end
      end
      PERM_READY: begin
        if (!controllerEnable) begin
          nxt_perm = PERM_OFF;
        end
      end
      default: begin
        nxt_perm = PERM_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      perm_ff <= PERM_OFF;
    end else begin
      perm_ff <= nxt_perm;
    end
  end

  // Initial-start skips the bus check; software owns that hazard
  assign startAllowed = controllerEnable & (perm_ff == PERM_READY) & ~busBusy_ff; // RULE_08

  // Read port, one cycle latency
  logic [7:0] rdMux;
  logic [7:0] rdData_ff;
  logic rdValid_ff;

  assign rdMux = selFlag ? flagValue : // RULE_01
                 selCr1 ? cr1Value :
                 UNMAPPED_READ;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rdData_ff <= UNMAPPED_READ;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= cpuRead;
      if (cpuRead) begin
        rdData_ff <= rdMux;
      end
    end
  end

  // Outputs
  assign cpuRdData = rdData_ff;
  assign cpuRdValid = rdValid_ff;
  assign startTriggerClear = trigClear_ff;
  assign initialStartEnable = initStart_ff;
  assign reservationDisable = rsvDisable_ff;
  assign busBusy = busBusy_ff;
  assign addressMatchWakeup = wakeup_ff;
  assign cr1Settings = cr1Set_ff;

endmodule

//--- sim/bus_flag_sva.sv
module bus_flag_sva
  import bus_flag_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic cpuBitMode,
  input wire logic [7:0] cpuWrData,
  input wire logic [7:0] cpuRdData,
  input wire logic cpuRdValid,
  // Controller side
  input wire logic controllerEnable,
  input wire logic startFail,
  input wire logic startTriggerClear,
  input wire logic startAllowed,
  input wire logic initialStartEnable,
  input wire logic reservationDisable,
  input wire logic busBusy,
  input wire logic addressMatchWakeup,
  input wire logic [1:0] cr1Settings,
  // Bus wires
  input wire logic serialClockPin,
  input wire logic serialDataPin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire flagWr = cpuWrite && cpuAddr == BUS_FLAG_ADDR;
  wire failTaken = startFail && controllerEnable && reservationDisable;
  sequence startOnPins;
    controllerEnable && serialClockPin && $fell(serialDataPin);
  endsequence
  sequence stopOnPins;
    controllerEnable && serialClockPin && $rose(serialDataPin);
  endsequence
  sequence enableWithInit;
    $rose(controllerEnable) && initialStartEnable;
  endsequence
  read_answer_a: assert property (cpuRead |=> cpuRdValid) else $error("read not answered");
  flag_layout_a: assert property (cpuRead && cpuAddr == BUS_FLAG_ADDR |=> cpuRdData[5:2] == 4'h0 &&
    cpuRdData[6] == $past(busBusy) && cpuRdData[0] == $past(reservationDisable)) else $error("flag byte wrong");
  rsv_hold_a: assert property (!(flagWr && !controllerEnable) |=> $stable(reservationDisable))
    else $error("reservation bit changed");
  init_set_a: assert property ($rose(initialStartEnable) |-> $past(flagWr && !controllerEnable))
    else $error("initial start set wrongly");
  setting_lock_a: assert property (controllerEnable |=> $stable(cr1Settings)) else $error("settings changed");
  wakeup_write_a: assert property (cpuWrite && !cpuBitMode && cpuAddr == CTRL_ONE_ADDR |=>
    addressMatchWakeup == $past(cpuWrData[7])) else $error("wakeup not written");
  fail_clear_a: assert property (failTaken |=> startTriggerClear) else $error("no trigger clear");
  clear_cause_a: assert property (startTriggerClear |-> $past(failTaken)) else $error("stray trigger clear");
  enable_busy_a: assert property ($rose(controllerEnable) && !initialStartEnable |-> ##[1:2] busBusy)
    else $error("busy not set on enable");
  off_idle_a: assert property (!controllerEnable |=> !busBusy) else $error("busy while disabled");
  allow_gate_a: assert property (startAllowed |-> controllerEnable && !busBusy) else $error("start allowed");
  init_allow_a: assert property (enableWithInit |=> startAllowed) else $error("initial start not allowed");
  start_busy_a: assert property (startOnPins |-> ##[2:8] (busBusy && !initialStartEnable))
    else $error("start not seen");
  stop_idle_a: assert property (stopOnPins |-> ##[2:8] !busBusy) else $error("stop not seen");
endmodule

bind i2c_bus_flag_register bus_flag_sva chk (.*);

//--- sim/bus_peer.sv
module bus_peer (
  // Bus wires, pulled up when released
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Link clock half period of 200 ns
  task automatic startCond();
    #200 sda = 1'b0;
    #200 scl = 1'b0;
  endtask
  // Clock low first so no false start
  task automatic stopCond();
    #200 scl = 1'b0;
    #200 sda = 1'b0;
    #200 scl = 1'b1;
    #200 sda = 1'b1;
  endtask
endmodule

//--- sim/i2c_bus_flag_register_tb.sv
module i2c_bus_flag_register_tb
  import bus_flag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, cpuWrite, cpuRead, cpuBitMode, cpuRdValid, controllerEnable, startTriggerWrite;
  logic startFail, startTriggerClear, startAllowed, initialStartEnable, reservationDisable, busBusy;
  logic addressMatchWakeup, serialClockPin, serialDataPin;
  logic [15:0] cpuAddr;
  logic [7:0] cpuWrData, cpuRdData;
  logic [2:0] cpuBitSel;
  logic [1:0] cr1Settings;
  int miscompares = 0;
  int numChecks = 0;

  i2c_bus_flag_register dut (.*);
  bus_peer peer (.scl(serialClockPin), .sda(serialDataPin));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (miscompares == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic chkBit(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bm = 1'b0, input logic [2:0] s = 3'h0);
    @(negedge ref_clk);
    cpuAddr = a;
    cpuWrData = d;
    cpuBitMode = bm;
    cpuBitSel = s;
    cpuWrite = 1'b1;
    @(negedge ref_clk);
    cpuWrite = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    cpuAddr = a;
    cpuRead = 1'b1;
    @(negedge ref_clk);
    // Valid stands for one cycle only
    chkBit(cpuRdValid, 1'b1);
    chk(cpuRdData, exp);
    cpuRead = 1'b0;
  endtask

  task automatic setEn(input logic v);
    @(negedge ref_clk);
    controllerEnable = v;
  endtask

  // Busy follows the pins a few edges late
  task automatic waitBusy(input logic exp);
    for (int i = 0; i < 40 && busBusy !== exp; i++) @(negedge ref_clk);
    if (busBusy !== exp) begin
      $display("unexpected at %0t: busy wait ran out", $time);
      miscompares++;
      test_done();
    end
  endtask

  task automatic fail(input logic exp);
    @(negedge ref_clk);
    startFail = 1'b1;
    @(negedge ref_clk);
    // Clear pulse lasts one cycle
    chkBit(startTriggerClear, exp);
    startFail = 1'b0;
  endtask

  task automatic flagPath();
    wr(BUS_FLAG_ADDR, 8'hff);
    rd(BUS_FLAG_ADDR, 8'h03);
    wr(BUS_FLAG_ADDR, 8'h00, 1'b1, 3'h1);
    rd(BUS_FLAG_ADDR, 8'h01);
    setEn(1'b1);
    wr(BUS_FLAG_ADDR, 8'h00);
    wr(BUS_FLAG_ADDR, 8'h01, 1'b1, 3'h1);
    rd(BUS_FLAG_ADDR, 8'h41);
    chkBit(startAllowed, 1'b0);
    peer.stopCond();
    waitBusy(1'b0);
    chkBit(startAllowed, 1'b1);
    peer.startCond();
    waitBusy(1'b1);
    peer.stopCond();
    waitBusy(1'b0);
  endtask

  task automatic failPath();
    fail(1'b1);
    rd(BUS_FLAG_ADDR, 8'h81);
    @(negedge ref_clk);
    startTriggerWrite = 1'b1;
    @(negedge ref_clk);
    startTriggerWrite = 1'b0;
    rd(BUS_FLAG_ADDR, 8'h01);
    fail(1'b1);
    setEn(1'b0);
    rd(BUS_FLAG_ADDR, 8'h01);
    wr(BUS_FLAG_ADDR, 8'h00);
    setEn(1'b1);
    fail(1'b0);
    rd(BUS_FLAG_ADDR, 8'h40);
  endtask

  task automatic initialStart();
    setEn(1'b0);
    wr(BUS_FLAG_ADDR, 8'h02);
    setEn(1'b1);
    repeat (2) @(negedge ref_clk);
    chkBit(busBusy, 1'b0);
    chkBit(startAllowed, 1'b1);
    // Bus idle and busy low above, so a first start is safe
    peer.startCond();
    waitBusy(1'b1);
    chkBit(initialStartEnable, 1'b0);
    peer.stopCond();
    waitBusy(1'b0);
  endtask

  task automatic ctrlOne();
    wr(CTRL_ONE_ADDR, 8'hff);
    chkBit(addressMatchWakeup, 1'b1);
    chk({6'h00, cr1Settings}, 8'h00);
    rd(CTRL_ONE_ADDR, 8'hb0);
    setEn(1'b0);
    wr(CTRL_ONE_ADDR, 8'h0c);
    rd(CTRL_ONE_ADDR, 8'h0c);
  endtask

  task automatic midReset();
    wr(BUS_FLAG_ADDR, 8'h03);
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(BUS_FLAG_ADDR, BUS_FLAG_RESET);
    rd(CTRL_ONE_ADDR, CTRL_ONE_RESET);
  endtask

  initial begin
    #2000000;
    $display("unexpected at %0t: run timed out", $time);
    miscompares++;
    test_done();
  end

  initial begin
    {reset_n, cpuWrite, cpuRead, cpuBitMode, controllerEnable, startTriggerWrite, startFail} = 7'h00;
    cpuAddr = 16'h0000;
    cpuWrData = 8'h00;
    cpuBitSel = 3'h0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(BUS_FLAG_ADDR, 8'h00);
    rd(CTRL_ONE_ADDR, 8'h00);
    rd(16'hff00, UNMAPPED_READ);
    flagPath();
    failPath();
    initialStart();
    ctrlOne();
    midReset();
    test_done();
  end
endmodule
